// ---- wmcu_bcd_ptr.sv ----
/*
 * wmcu_bcd_ptr: checks a 4-digit BCD pointer and converts it to binary.
 * assumes the caller registers the result; purely combinational.
 */
`default_nettype none
module wmcu_bcd_ptr #(
    parameter int LIMIT = 32
) (
    // pointer in
    input  wire logic [15:0] ptr_in,
    // decoded index and validity
    output logic      [15:0] idx_out,
    output logic             bad_out
);
    import wmcu_pkg::*;
    logic [3:0] d0, d1, d2, d3;
    logic       not_bcd;
    // digit split and range check
    assign d0      = ptr_in[3:0];
    assign d1      = ptr_in[7:4];
    assign d2      = ptr_in[11:8];
    assign d3      = ptr_in[15:12];
    assign not_bcd = (d0 > 4'h9) | (d1 > 4'h9) | (d2 > 4'h9) | (d3 > 4'h9);
    assign idx_out = 16'(d0) + 16'(d1) * 16'h000A + 16'(d2) * 16'h0064
                   + 16'(d3) * 16'h03E8;
    assign bad_out = not_bcd | (idx_out >= 16'(LIMIT));
endmodule
`default_nettype wire

// ---- wmcu_core.sv ----
/*
 * wmcu_core: word copy, inverted copy, three-way compare and range-table
 * compare datapath with match/below/above/fault flags.
 * assumes a sequencer on the same clock issuing one step per pulse,
 * with the ladder condition of the current scan on EXEC_COND_IN.
 */
// Behaviour
// RULE1 - a true copy writes the source unchanged, a false one does nothing.
// RULE2 - a true inverted copy writes the complement of the source.
// RULE3 - a false inverted copy leaves destination and flags alone.
// RULE4 - both copies set match when the written value is zero, else clear.
// RULE5 - fault rises when an indirect pointer is not BCD or out of range.
// RULE6 - a copy with a held true condition runs again on every step.
// RULE7 - a false compare leaves above, match and below as they were.
// RULE8 - a true compare sets exactly one of match, below or above.
// RULE9 - below, match and above sit at bit addresses 0313, 0314, 0315.
// RULE10 - flags hold only until a later instruction rewrites them.
// RULE11 - the program supplies BCD values when comparing present counts.
// RULE12 - range result goes only to io word 01, work or data area.
// RULE13 - range base is data word 00 to 13; the value may come from anywhere.
// RULE14 - range count is lowest base digit plus one, limit pairs follow.
// RULE15 - result bit set inside a normal range, outside a reversed one.
// RULE16 - fault sits at bit address 0311 and flags bad operands.
// RULE17 - each step uses the condition computed earlier in the same scan.
`default_nettype none
module wmcu_core
    import wmcu_pkg::*;
#(
    parameter int WORD_W     = wmcu_pkg::WMCU_WORD_W,
    parameter int DATA_WORDS = wmcu_pkg::WMCU_DATA_WORDS
) (
    // clock and reset
    input  wire logic                 SYS_CLK_IN,
    input  wire logic                 SYS_RST_IN,
    // instruction step from the sequencer
    input  wire logic                 STEP_IN,
    input  wire logic [5:0]           OPCODE_IN,
    input  wire logic                 EXEC_COND_IN,
    input  wire logic [WORD_W-1:0]    FIRST_OPERAND_IN,
    input  wire logic [WORD_W-1:0]    SECOND_OPERAND_IN,
    input  wire logic                 INDIRECT_IN,
    input  wire logic [WORD_W-1:0]    POINTER_IN,
    input  wire logic [WORD_W-1:0]    RANGE_TABLE_BASE_IN,
    // data area write port from the sequencer
    input  wire logic                 DATA_WR_IN,
    input  wire logic [4:0]           DATA_ADDR_IN,
    input  wire logic [WORD_W-1:0]    DATA_WDATA_IN,
    // results
    output logic                      DEST_WR_OUT,
    output logic      [WORD_W-1:0]    DEST_DATA_OUT,
    output logic                      BUSY_OUT,
    output logic                      DONE_OUT,
    // dedicated-area flags
    output logic                      FAULT_FLAG_OUT,
    output logic                      BELOW_FLAG_OUT,
    output logic                      MATCH_FLAG_OUT,
    output logic                      ABOVE_FLAG_OUT
);
    import wmcu_pkg::*;

    logic [WORD_W-1:0] data_area [DATA_WORDS];
    wmcu_state_t       state_q, state_d;
    logic [15:0]       ptr_idx;
    logic              ptr_bad;
    logic [WORD_W-1:0] src_word;
    logic [WORD_W-1:0] copy_val;
    logic              is_copy, is_inv, is_cmp, is_rng, go;
    logic              cmp_lt, cmp_eq, cmp_gt;
    logic              base_bad;
    logic [4:0]        base_idx;
    logic [3:0]        rng_cnt;
    logic [3:0]        rng_i_q;
    logic [WORD_W-1:0] value_q;
    logic [WORD_W-1:0] result_q;
    logic [WORD_W-1:0] lo_w, hi_w;
    logic              in_rng, hit;
    logic              rev_lim, out_rng;
    logic              busy_q;
    logic              last_rng;
    logic [4:0]        lo_addr, hi_addr;
    logic              dest_wr_q, done_q, fault_q, below_q, match_q, above_q;
    logic [WORD_W-1:0] dest_q;

    // indirect pointer check
    // a pointer past the area reads a wrapped word; the fault blocks it for copy and compare, not for range
    wmcu_bcd_ptr #(.LIMIT(DATA_WORDS)) u_ptr (
        .ptr_in  (POINTER_IN),
        .idx_out (ptr_idx),
        .bad_out (ptr_bad)
    );

    // decode of the step; the condition is this scan's ladder result
    assign go       = STEP_IN & EXEC_COND_IN
                    & (state_q == WMCU_IDLE);                   // RULE17
    assign is_copy  = go & (OPCODE_IN == WMCU_OP_COPY);
    assign is_inv   = go & (OPCODE_IN == WMCU_OP_INVCOPY);
    assign is_cmp   = go & (OPCODE_IN == WMCU_OP_CMP3);
    assign is_rng   = go & (OPCODE_IN == WMCU_OP_RANGE);
    assign src_word = INDIRECT_IN ? data_area[ptr_idx[4:0]]
                                  : FIRST_OPERAND_IN;
    assign copy_val = is_inv ? ~src_word : src_word; // RULE2
    assign cmp_lt   = src_word < SECOND_OPERAND_IN;
    assign cmp_eq   = src_word == SECOND_OPERAND_IN;
    assign cmp_gt   = src_word > SECOND_OPERAND_IN;

    // range table walk: base word, then lower/upper pairs
    // the table is read live, so a write during the walk is seen at once
    assign base_bad = RANGE_TABLE_BASE_IN > WMCU_BASE_MAX;
    assign base_idx = RANGE_TABLE_BASE_IN[4:0];
    assign rng_cnt  = data_area[base_idx][3:0];                  // RULE14
    assign lo_addr  = 5'(base_idx + 5'(2 * rng_i_q) + 5'h01);
    assign hi_addr  = 5'(base_idx + 5'(2 * rng_i_q) + 5'h02);
    assign lo_w     = data_area[lo_addr];
    assign hi_w     = data_area[hi_addr];
    // reversed limits: the band between them is the miss zone
    assign rev_lim  = lo_w > hi_w;
    assign in_rng   = (value_q >= lo_w) & (value_q <= hi_w);
    assign out_rng  = (value_q <= hi_w) | (value_q >= lo_w);
    assign hit      = rev_lim ? out_rng : in_rng;               // RULE15
    assign last_rng = rng_i_q == rng_cnt;

    // state sequencing
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            WMCU_IDLE:  if (is_rng && !base_bad) state_d = WMCU_SCAN;
            WMCU_FETCH: state_d = WMCU_SCAN;
            WMCU_SCAN:  if (last_rng) state_d = WMCU_IDLE;
        endcase
    end

    // data area storage, written by the sequencer
    always_ff @(posedge SYS_CLK_IN) begin
        if (DATA_WR_IN) begin
            data_area[DATA_ADDR_IN] <= DATA_WDATA_IN;
        end
    end

    // control state and range progress
    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            state_q  <= WMCU_IDLE;
            busy_q   <= 1'b0;
            rng_i_q  <= 4'h0;
            value_q  <= '0;
            result_q <= '0;
        end else begin
            state_q <= state_d;
            // busy is a flop copy of the next state, no decode at the pin
            busy_q  <= state_d != WMCU_IDLE;
            if (is_rng) begin
                rng_i_q  <= 4'h0;
                value_q  <= src_word;
                result_q <= '0;
            end else if (state_q == WMCU_SCAN) begin
                rng_i_q            <= rng_i_q + 4'h1;
                result_q[rng_i_q]  <= hit;                       // RULE15
            end
        end
    end

    // destination write strobe and data
    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            dest_wr_q <= 1'b0;
            dest_q    <= '0;
            done_q    <= 1'b0;
        end else begin
            dest_wr_q <= 1'b0;
            done_q    <= 1'b0;
            // every true copy step without a bad indirect pointer writes again, no edge memory here
            if ((is_copy || is_inv) && !(INDIRECT_IN && ptr_bad)) begin
                dest_wr_q <= 1'b1;                           // RULE1 RULE6
                dest_q    <= copy_val;
            end
            // the last bit goes straight from the compare into the word
            if (state_q == WMCU_SCAN && last_rng) begin
                dest_wr_q <= 1'b1;
                dest_q    <= result_q;
                dest_q[rng_i_q] <= hit;
            end
            done_q <= (go && !is_rng) || (is_rng && base_bad)
                   || (state_q == WMCU_SCAN && last_rng);
        end
    end

    // flags: held until the next flag-affecting step
    always_ff @(posedge SYS_CLK_IN) begin
        if (SYS_RST_IN) begin
            fault_q <= 1'b0;
            below_q <= 1'b0;
            match_q <= 1'b0;
            above_q <= 1'b0;
        end else begin
            // every executed step rewrites fault, good or bad
            if (go) begin
                fault_q <= (INDIRECT_IN & ptr_bad)
                         | (is_rng & base_bad);          // RULE5 RULE16
            end
            if ((is_copy || is_inv) && !(INDIRECT_IN && ptr_bad)) begin
                match_q <= copy_val == WMCU_ZERO;        // RULE4 RULE10
            end
            if (is_cmp && !(INDIRECT_IN && ptr_bad)) begin
                below_q <= cmp_lt;                       // RULE8 RULE9
                match_q <= cmp_eq;
                above_q <= cmp_gt;
            end
            // false condition: go is low, nothing changes  RULE3 RULE7
        end
    end

    // outputs straight from flip-flops
    assign DEST_WR_OUT    = dest_wr_q;
    assign DEST_DATA_OUT  = dest_q;
    assign BUSY_OUT       = busy_q;
    assign DONE_OUT       = done_q;
    assign FAULT_FLAG_OUT = fault_q;
    assign BELOW_FLAG_OUT = below_q;
    assign MATCH_FLAG_OUT = match_q;
    assign ABOVE_FLAG_OUT = above_q;
endmodule
`default_nettype wire

// ---- wmcu_core_sva.sv ----
/* wmcu_core_sva: port assertions for the move/compare datapath.
   assumes default word width and binding to every wmcu_core. */
`default_nettype none
module wmcu_core_sva
    import wmcu_pkg::*;
(
    // clock, reset, step inputs and result outputs
    input wire logic        SYS_CLK_IN, SYS_RST_IN, STEP_IN, EXEC_COND_IN,
    input wire logic        INDIRECT_IN, DEST_WR_OUT, BUSY_OUT, DONE_OUT,
    input wire logic [5:0]  OPCODE_IN,
    input wire logic [15:0] FIRST_OPERAND_IN, SECOND_OPERAND_IN,
    input wire logic [15:0] POINTER_IN, RANGE_TABLE_BASE_IN, DEST_DATA_OUT,
    // flags
    input wire logic        FAULT_FLAG_OUT, BELOW_FLAG_OUT,
    input wire logic        MATCH_FLAG_OUT, ABOVE_FLAG_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    // decode of taken steps
    wire logic tk = STEP_IN && EXEC_COND_IN && !BUSY_OUT;
    wire logic cp = tk && !INDIRECT_IN && OPCODE_IN == WMCU_OP_COPY;
    wire logic iv = tk && !INDIRECT_IN && OPCODE_IN == WMCU_OP_INVCOPY;
    wire logic c3 = tk && !INDIRECT_IN && OPCODE_IN == WMCU_OP_CMP3;
    wire logic rg = tk && OPCODE_IN == WMCU_OP_RANGE
                    && RANGE_TABLE_BASE_IN <= WMCU_BASE_MAX;
    wire logic [3:0] fl = {FAULT_FLAG_OUT, BELOW_FLAG_OUT,
                           MATCH_FLAG_OUT, ABOVE_FLAG_OUT};
    default clocking @(posedge SYS_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    copy_value_a: assert property (cp |=> DEST_WR_OUT
        && DEST_DATA_OUT == $past(FIRST_OPERAND_IN)) else $error("copy");
    inv_value_a: assert property (iv |=> DEST_WR_OUT
        && DEST_DATA_OUT == ~$past(FIRST_OPERAND_IN)) else $error("inv");
    copy_match_a: assert property ((cp || iv) |=> !FAULT_FLAG_OUT
        && MATCH_FLAG_OUT == (DEST_DATA_OUT == WMCU_ZERO)) else $error("eq");
    idle_cond_a: assert property (STEP_IN && !EXEC_COND_IN
        && !BUSY_OUT |=> !DONE_OUT && !DEST_WR_OUT && $stable(fl))
        else $error("false condition acted");
    cmp_flags_a: assert property (c3 |=> $onehot(fl[2:0])
        && MATCH_FLAG_OUT == ($past(FIRST_OPERAND_IN)
                              == $past(SECOND_OPERAND_IN))
        && BELOW_FLAG_OUT == ($past(FIRST_OPERAND_IN)
                              < $past(SECOND_OPERAND_IN)))
        else $error("compare flags");
    bad_ptr_a: assert property (tk && INDIRECT_IN
        && POINTER_IN[15:8] != 8'h00 |=> FAULT_FLAG_OUT && !DEST_WR_OUT)
        else $error("bad pointer");
    flag_hold_a: assert property (!STEP_IN && !BUSY_OUT
        |=> $stable(fl)) else $error("flags moved");
    range_done_a: assert property (rg |=> BUSY_OUT
        ##[1:16] (DONE_OUT && DEST_WR_OUT)) else $error("range timing");
    step_done_a: assert property ((cp || c3) |=> DONE_OUT)
        else $error("no done");
    // main scenarios
    cover property (cp ##1 MATCH_FLAG_OUT);
    cover property (c3 ##1 ABOVE_FLAG_OUT);
    cover property (rg ##2 DONE_OUT);
endmodule
bind wmcu_core wmcu_core_sva i_wmcu_core_sva (
    .SYS_CLK_IN          (SYS_CLK_IN),
    .SYS_RST_IN          (SYS_RST_IN),
    .STEP_IN             (STEP_IN),
    .EXEC_COND_IN        (EXEC_COND_IN),
    .INDIRECT_IN         (INDIRECT_IN),
    .DEST_WR_OUT         (DEST_WR_OUT),
    .BUSY_OUT            (BUSY_OUT),
    .DONE_OUT            (DONE_OUT),
    .OPCODE_IN           (OPCODE_IN),
    .FIRST_OPERAND_IN    (FIRST_OPERAND_IN),
    .SECOND_OPERAND_IN   (SECOND_OPERAND_IN),
    .POINTER_IN          (POINTER_IN),
    .RANGE_TABLE_BASE_IN (RANGE_TABLE_BASE_IN),
    .DEST_DATA_OUT       (DEST_DATA_OUT),
    .FAULT_FLAG_OUT      (FAULT_FLAG_OUT),
    .BELOW_FLAG_OUT      (BELOW_FLAG_OUT),
    .MATCH_FLAG_OUT      (MATCH_FLAG_OUT),
    .ABOVE_FLAG_OUT      (ABOVE_FLAG_OUT)
);
`default_nettype wire

// ---- wmcu_pkg.sv ----
/*
 * wmcu_pkg: shared constants for the word move / compare datapath.
 * assumes a 16-bit BCD word machine with a small data area.
 */
`default_nettype none
package wmcu_pkg;
    localparam int          WMCU_WORD_W      = 16;
    localparam int          WMCU_DATA_WORDS  = 32;   // data area depth
    localparam int          WMCU_RANGE_MAX   = 16;   // ranges per table
    // opcodes as issued by the sequencer
    localparam logic [5:0]  WMCU_OP_COPY     = 6'h1E; // 30
    localparam logic [5:0]  WMCU_OP_INVCOPY  = 6'h1F; // 31
    localparam logic [5:0]  WMCU_OP_CMP3     = 6'h20; // 32
    localparam logic [5:0]  WMCU_OP_RANGE    = 6'h22; // 34
    // dedicated-area bit addresses of the flags
    localparam logic [15:0] WMCU_ADDR_FAULT  = 16'h0311;
    localparam logic [15:0] WMCU_ADDR_BELOW  = 16'h0313;
    localparam logic [15:0] WMCU_ADDR_MATCH  = 16'h0314;
    localparam logic [15:0] WMCU_ADDR_ABOVE  = 16'h0315;
    // highest legal range table base word
    localparam logic [15:0] WMCU_BASE_MAX    = 16'h0013;
    localparam logic [15:0] WMCU_ZERO        = 16'h0000;
    typedef enum logic [1:0] {
        WMCU_IDLE, WMCU_FETCH, WMCU_SCAN
    } wmcu_state_t;
endpackage
`default_nettype wire

// ---- word_move_compare_unit_tb_top.sv ----
/* word_move_compare_unit_tb_top: directed tests of the datapath.
   assumes wmcu_pkg, wmcu_core and the bound checker are compiled. */
`default_nettype none
module word_move_compare_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import wmcu_pkg::*;
    // design stimulus and observation
    logic SYS_CLK_IN = 1'h0, SYS_RST_IN = 1'h1, STEP_IN = 1'h0;
    logic EXEC_COND_IN = 1'h0, INDIRECT_IN = 1'h0, DATA_WR_IN = 1'h0;
    logic [5:0] OPCODE_IN = 6'h00;
    logic [4:0] DATA_ADDR_IN = 5'h00;
    logic [15:0] FIRST_OPERAND_IN = 16'h0, SECOND_OPERAND_IN = 16'h0;
    logic [15:0] POINTER_IN = 16'h0, RANGE_TABLE_BASE_IN = 16'h0;
    logic [15:0] DATA_WDATA_IN = 16'h0, DEST_DATA_OUT;
    logic DEST_WR_OUT, BUSY_OUT, DONE_OUT, FAULT_FLAG_OUT, BELOW_FLAG_OUT;
    logic MATCH_FLAG_OUT, ABOVE_FLAG_OUT;
    int mismatches = 0, samples_checked = 0, cycles = 0;
    wmcu_core i_wmcu_core (
        .SYS_CLK_IN          (SYS_CLK_IN),
        .SYS_RST_IN          (SYS_RST_IN),
        .STEP_IN             (STEP_IN),
        .OPCODE_IN           (OPCODE_IN),
        .EXEC_COND_IN        (EXEC_COND_IN),
        .FIRST_OPERAND_IN    (FIRST_OPERAND_IN),
        .SECOND_OPERAND_IN   (SECOND_OPERAND_IN),
        .INDIRECT_IN         (INDIRECT_IN),
        .POINTER_IN          (POINTER_IN),
        .RANGE_TABLE_BASE_IN (RANGE_TABLE_BASE_IN),
        .DATA_WR_IN          (DATA_WR_IN),
        .DATA_ADDR_IN        (DATA_ADDR_IN),
        .DATA_WDATA_IN       (DATA_WDATA_IN),
        .DEST_WR_OUT         (DEST_WR_OUT),
        .DEST_DATA_OUT       (DEST_DATA_OUT),
        .BUSY_OUT            (BUSY_OUT),
        .DONE_OUT            (DONE_OUT),
        .FAULT_FLAG_OUT      (FAULT_FLAG_OUT),
        .BELOW_FLAG_OUT      (BELOW_FLAG_OUT),
        .MATCH_FLAG_OUT      (MATCH_FLAG_OUT),
        .ABOVE_FLAG_OUT      (ABOVE_FLAG_OUT)
    );
    // clock and hang guard
    initial forever #20 SYS_CLK_IN = ~SYS_CLK_IN;
    always @(posedge SYS_CLK_IN) if (++cycles == 3000) begin
        mismatches++;
        finish_test();
    end
    task automatic chk(input logic [15:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic step(input logic [5:0] op, input logic c, ind,
                        input logic [15:0] a, b);
        @(posedge SYS_CLK_IN);
        #1 STEP_IN = 1'h1;
        OPCODE_IN = op;
        EXEC_COND_IN = c;
        INDIRECT_IN = ind;
        FIRST_OPERAND_IN = a;
        SECOND_OPERAND_IN = b;
        @(posedge SYS_CLK_IN);
        #1 STEP_IN = 1'h0;
    endtask
    task automatic wr(input logic [4:0] ad, input logic [15:0] d);
        @(posedge SYS_CLK_IN);
        #1 {DATA_WR_IN, DATA_ADDR_IN, DATA_WDATA_IN} = {1'h1, ad, d};
        @(posedge SYS_CLK_IN);
        #1 DATA_WR_IN = 1'h0;
    endtask
    task automatic t_move();
        step(WMCU_OP_COPY, 1'h1, 1'h0, 16'h1234, 16'h0);
        chk(DEST_DATA_OUT, 16'h1234);
        chk({DONE_OUT, DEST_WR_OUT, MATCH_FLAG_OUT}, 16'h6);
        step(WMCU_OP_INVCOPY, 1'h1, 1'h0, 16'h00FF, 16'h0);
        chk(DEST_DATA_OUT, 16'hFF00);
        step(WMCU_OP_INVCOPY, 1'h1, 1'h0, 16'hFFFF, 16'h0);
        chk(MATCH_FLAG_OUT, 16'h1);
        chk(DEST_DATA_OUT, 16'h0000);
        step(WMCU_OP_INVCOPY, 1'h0, 1'h0, 16'h1234, 16'h0);
        chk(DONE_OUT, 16'h0);
        chk(DEST_DATA_OUT, 16'h0000);
        chk(MATCH_FLAG_OUT, 16'h1);
        $display("test move done");
    endtask
    task automatic t_cmp();
        logic [15:0] a [3] = '{16'h0005, 16'h0007, 16'h0009};
        for (int i = 0; i < 3; i++) begin
            step(WMCU_OP_CMP3, 1'h1, 1'h0, a[i], 16'h0007);
            chk({ABOVE_FLAG_OUT, MATCH_FLAG_OUT, BELOW_FLAG_OUT},
                16'h1 << i);
        end
        step(WMCU_OP_CMP3, 1'h0, 1'h0, 16'h0005, 16'h0007);
        chk({ABOVE_FLAG_OUT, MATCH_FLAG_OUT, BELOW_FLAG_OUT}, 16'h4);
        step(WMCU_OP_COPY, 1'h1, 1'h0, 16'h0000, 16'h0);
        chk({ABOVE_FLAG_OUT, MATCH_FLAG_OUT, BELOW_FLAG_OUT}, 16'h6);
        $display("test compare done");
    endtask
    task automatic t_ptr();
        wr(5'h05, 16'hBEEF);
        POINTER_IN = 16'h0005;
        step(WMCU_OP_COPY, 1'h1, 1'h1, 16'h0, 16'h0);
        chk(FAULT_FLAG_OUT, 16'h0);
        chk(DEST_DATA_OUT, 16'hBEEF);
        POINTER_IN = 16'h001A;
        step(WMCU_OP_COPY, 1'h1, 1'h1, 16'h0, 16'h0);
        chk({FAULT_FLAG_OUT, DEST_WR_OUT}, 16'h2);
        POINTER_IN = 16'h0032;
        step(WMCU_OP_COPY, 1'h1, 1'h1, 16'h0, 16'h0);
        chk({FAULT_FLAG_OUT, DEST_WR_OUT}, 16'h2);
        POINTER_IN = 16'h0120;
        step(WMCU_OP_CMP3, 1'h1, 1'h1, 16'h0, 16'h0);
        chk({FAULT_FLAG_OUT, DEST_WR_OUT}, 16'h2);
        step(WMCU_OP_COPY, 1'h1, 1'h0, 16'h0001, 16'h0);
        chk(FAULT_FLAG_OUT, 16'h0);
        $display("test pointer done");
    endtask
    task automatic t_rng(input logic [15:0] cd, input logic [1:0] exp);
        int n = 0;
        step(WMCU_OP_RANGE, 1'h1, 1'h0, cd, 16'h0);
        chk(BUSY_OUT, 16'h1);
        while (DONE_OUT !== 1'h1 && n < 20) begin
            @(posedge SYS_CLK_IN);
            #1 n++;
        end
        chk(16'(n), 16'h2);
        chk(BUSY_OUT, 16'h0);
        chk({DEST_WR_OUT, DEST_DATA_OUT[1:0]}, {14'h1, exp});
        $display("test range done");
    endtask
    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge SYS_CLK_IN);
        #1 SYS_RST_IN = 1'h0;
        t_move();
        t_cmp();
        t_ptr();
        wr(5'h00, 16'h0001);
        wr(5'h01, 16'h0010);
        wr(5'h02, 16'h0020);
        wr(5'h03, 16'h0050);
        wr(5'h04, 16'h0030);
        RANGE_TABLE_BASE_IN = 16'h0000;
        t_rng(16'h0015, 2'h3);
        t_rng(16'h0060, 2'h2);
        t_rng(16'h0040, 2'h0);
        finish_test();
    end
endmodule
`default_nettype wire
